// File: rtl/stim_one_decode.sv
// first-stimulus detect and response switch decoder
`timescale 1ns/10ps
module stim_one_decode #(
  parameter int AW = 6
) (
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  // profile memory programming
  input  wire logic          mem_wr_en,
  input  wire logic [AW-1:0] mem_wr_addr,
  input  wire logic [7:0]    mem_wr_data,
  // profile load request
  input  wire logic          load_req,
  input  wire logic [3:0]    profile_sel,
  output logic               load_busy,
  // register read port
  input  wire logic [7:0]    rd_addr,
  output logic [7:0]         rd_data,
  // sequencing
  input  wire logic          emu_reset,
  input  wire logic          arm,
  output logic               stim_hit,
  output logic               stim_done,
  // analog comparator pins
  input  wire logic          vbus_ready_pin,
  input  wire logic          vbus_present_pin,
  input  wire logic          dp_above_th_pin,
  input  wire logic          dm_above_th_pin,
  input  wire logic          dp_above_floor_pin,
  output logic [3:0]         threshold_code,
  // switch controls
  output logic               dp_volt_en,
  output logic               dm_volt_en,
  output logic [3:0]         volt_mag,
  output logic               dp_res_en,
  output logic               dm_res_en,
  output logic [3:0]         res_mag,
  output logic               dp_div_en,
  output logic               dm_div_en,
  output logic [3:0]         div_mag,
  output logic               bridge_en,
  output logic               dp_pd15k_en,
  output logic               dm_pd15k_en,
  output logic               pd_cur_en,
  output logic [1:0]         pd_cur_code
);
  import stim_one_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic [1:0] resp_pins(input logic [3:0] c);
    case (c)
      RESP_VOLT_DP, RESP_RES_DP, RESP_DIV_DP:       resp_pins = 2'b10;
      RESP_VOLT_DM, RESP_RES_DM, RESP_DIV_DM:       resp_pins = 2'b01;
      RESP_VOLT_BOTH, RESP_RES_BOTH, RESP_DIV_BOTH: resp_pins = 2'b11;
      default:                                      resp_pins = 2'b00;
    endcase
  endfunction : resp_pins

  // pin state is {volt, res, div, pd15k}
  function automatic logic [3:0] next_pin(
    input logic [3:0] cur,
    input logic       touched,
    input logic [3:0] c,
    input logic [2:0] sel,
    input logic       vo,
    input logic       rs,
    input logic       dv
  );
    logic busy;
    busy = cur[3] | cur[2] | cur[1];
    next_pin = cur;
    if (c == RESP_REMOVE) begin
      next_pin = 4'b0000;
    end else if (touched) begin
      next_pin = {vo, rs, dv, 1'b0};
    end else if (c == RESP_KEEP_A || c == RESP_KEEP_B) begin
      if (sel == SEL_VBUS_POST) begin
        next_pin = {cur[3:1], 1'b0};
      end
    end else if (vo | rs | dv | (c == RESP_BRIDGE)) begin
      next_pin = {cur[3:1], cur[0] & (sel == SEL_VBUS_PRE) & ~busy & (c != RESP_BRIDGE)};
    end
  endfunction : next_pin

  // ==========================================================
  // pin synchronisers
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
    end else begin
      pin_meta <= {vbus_ready_pin, vbus_present_pin, dp_above_th_pin,
                   dm_above_th_pin, dp_above_floor_pin};
      pin_sync <= pin_meta;
    end
  end

  wire vbus_ready   = pin_sync[4];
  wire vbus_present = pin_sync[3];
  wire dp_hi        = pin_sync[2];
  wire dm_hi        = pin_sync[1];
  wire dp_floor     = pin_sync[0];

  // ==========================================================
  // profile fetch from internal memory
  load_state_t     load_state;
  logic [1:0]      load_idx;
  logic [1:0]      cap_idx;
  logic            cap_valid;
  logic [3:0]      load_prof;
  logic [7:0]      mem_rd_data;
  logic [7:0]      reg_sel_timer;
  logic [7:0]      reg_resp_mag;
  logic [7:0]      reg_pd_th;

  wire [AW-1:0] mem_rd_addr =
    AW'({load_prof, load_idx});

  profile_store #(
    .WIDTH (8),
    .DEPTH (1 << AW),
    .AW    (AW)
  ) u_store (
    .sys_clk (sys_clk),
    .wr_en   (mem_wr_en),
    .wr_addr (mem_wr_addr),
    .wr_data (mem_wr_data),
    .rd_addr (mem_rd_addr),
    .rd_data (mem_rd_data)
  );

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      load_state <= LOAD_IDLE;
      load_idx   <= 2'd0;
      load_prof  <= 4'h0;
      cap_valid  <= 1'b0;
      cap_idx    <= 2'd0;
    end else begin
      cap_valid <= (load_state == LOAD_FETCH);
      cap_idx   <= load_idx;
      case (load_state)
        LOAD_IDLE: begin
          if (load_req) begin
            load_prof  <= profile_sel;
            load_idx   <= 2'd0;
            load_state <= LOAD_FETCH;
          end
        end
        LOAD_FETCH: begin
          if (load_idx == LOAD_LAST) begin
            load_state <= LOAD_DRAIN;
          end else begin
            load_idx <= load_idx + 2'd1;
          end
        end
        LOAD_DRAIN: load_state <= LOAD_IDLE;
        default:    load_state <= LOAD_IDLE;
      endcase
    end
  end

  // ==========================================================
  // configuration registers, written only by the fetch
  wire [3:0] new_mag = mem_rd_data[MAG_LSB +: 4];
  wire [3:0] new_th  = mem_rd_data[TH_LSB +: 4];
  wire [3:0] kept_mag =
    (new_mag == MAG_DO_NOT_USE) ? reg_resp_mag[MAG_LSB +: 4] : new_mag;
  wire [3:0] kept_th =
    (new_th == TH_DO_NOT_USE) ? reg_pd_th[TH_LSB +: 4] : new_th;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      reg_sel_timer <= RST_SEL_TIMER;
      reg_resp_mag  <= RST_RESP_MAG;
      reg_pd_th     <= RST_PD_TH;
    end else if (cap_valid) begin
      case (cap_idx)
        2'd0:    reg_sel_timer <= {1'b0, mem_rd_data[6:0]};
        2'd1:    reg_resp_mag  <= {kept_mag, mem_rd_data[RESP_LSB +: 4]};
        2'd2:    reg_pd_th     <= {2'b00, mem_rd_data[PUPD_LSB +: 2], kept_th};
        default: reg_pd_th     <= reg_pd_th;
      endcase
    end
  end

  // read only: there is no write path from the host side
  wire [7:0] next_rd_data =
    (rd_addr == ADDR_SEL_TIMER) ? reg_sel_timer :
    (rd_addr == ADDR_RESP_MAG)  ? reg_resp_mag  :
    (rd_addr == ADDR_PD_TH)     ? reg_pd_th     : READ_UNMAPPED;

  // ==========================================================
  // field decode
  wire [2:0] sel  = reg_sel_timer[SEL_LSB +: 3];
  wire [3:0] code = reg_resp_mag[RESP_LSB +: 4];
  wire [3:0] mag  = reg_resp_mag[MAG_LSB +: 4];
  wire [1:0] pupd = reg_pd_th[PUPD_LSB +: 2];

  // ==========================================================
  // stimulus detect
  logic cond;
  always_comb begin
    case (sel)
      SEL_VBUS_PRE:  cond = vbus_ready;
      SEL_DP_HI_A:   cond = dp_hi;
      SEL_DP_HI_B:   cond = dp_hi;
      SEL_DM_HI:     cond = dm_hi;
      SEL_DP_WINDOW: cond = ~dp_hi & dp_floor;
      SEL_VBUS_POST: cond = vbus_present;
      default:       cond = 1'b0;
    endcase
  end

  // vbus selects complete at once; comparator selects wait for release
  wire no_wait = (sel == SEL_VBUS_PRE) || (sel == SEL_VBUS_POST);
  logic armed;
  logic hit_seen;
  wire  fire = armed & cond & ~load_busy;

  always_ff @(posedge sys_clk) begin
    if (!rstn || emu_reset) begin
      armed     <= 1'b0;
      hit_seen  <= 1'b0;
      stim_hit  <= 1'b0;
      stim_done <= 1'b0;
    end else begin
      stim_hit <= fire;
      if (fire) begin
        armed     <= 1'b0;
        hit_seen  <= 1'b1;
        stim_done <= no_wait;
      end else if (arm) begin
        armed     <= 1'b1;
        hit_seen  <= 1'b0;
        stim_done <= 1'b0;
      end else if (hit_seen && !cond) begin
        stim_done <= 1'b1;
      end
    end
  end

  // threshold only matters for comparator selects
  wire [3:0] next_th = no_wait ? 4'h0 : reg_pd_th[TH_LSB +: 4];

  // ==========================================================
  // response decode
  wire       is_volt = (code == RESP_VOLT_DP) || (code == RESP_VOLT_DM) ||
                       (code == RESP_VOLT_BOTH);
  wire       is_res  = (code == RESP_RES_DP) || (code == RESP_RES_DM) ||
                       (code == RESP_RES_BOTH);
  wire       is_div  = (code == RESP_DIV_DP) || (code == RESP_DIV_DM) ||
                       (code == RESP_DIV_BOTH);
  wire [1:0] pins    = resp_pins(code);

  wire [3:0] dp_cur = {dp_volt_en, dp_res_en, dp_div_en, dp_pd15k_en};
  wire [3:0] dm_cur = {dm_volt_en, dm_res_en, dm_div_en, dm_pd15k_en};
  wire [3:0] dp_nxt = next_pin(dp_cur, pins[1], code, sel, is_volt, is_res, is_div);
  wire [3:0] dm_nxt = next_pin(dm_cur, pins[0], code, sel, is_volt, is_res, is_div);

  wire next_bridge = (code == RESP_BRIDGE) ? 1'b1 :
                     (code == RESP_REMOVE) ? 1'b0 : bridge_en;
  wire pd_cur_on   = is_volt && (mag == MAG_PULLDOWN);
  wire next_pd_cur = is_volt ? pd_cur_on :
                     (code == RESP_REMOVE) ? 1'b0 : pd_cur_en;

  // ==========================================================
  // switch control registers, updated only on a stimulus
  always_ff @(posedge sys_clk) begin
    if (!rstn || emu_reset) begin
      {dp_volt_en, dp_res_en, dp_div_en, dp_pd15k_en} <= 4'b0001;
      {dm_volt_en, dm_res_en, dm_div_en, dm_pd15k_en} <= 4'b0001;
      bridge_en   <= 1'b0;
      volt_mag    <= 4'h0;
      res_mag     <= 4'h0;
      div_mag     <= 4'h0;
      pd_cur_en   <= 1'b0;
      pd_cur_code <= 2'b00;
    end else if (fire) begin
      {dp_volt_en, dp_res_en, dp_div_en, dp_pd15k_en} <= dp_nxt;
      {dm_volt_en, dm_res_en, dm_div_en, dm_pd15k_en} <= dm_nxt;
      bridge_en <= next_bridge;
      pd_cur_en <= next_pd_cur;
      if (is_volt) begin
        volt_mag    <= mag;
        pd_cur_code <= pupd;
      end
      if (is_res) begin
        res_mag <= mag;
      end
      if (is_div) begin
        div_mag <= mag;
      end
    end
  end

  // ==========================================================
  // registered status outputs
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rd_data        <= READ_UNMAPPED;
      threshold_code <= 4'h0;
      load_busy      <= 1'b0;
    end else begin
      rd_data        <= next_rd_data;
      threshold_code <= next_th;
      load_busy      <= (load_state != LOAD_IDLE) || load_req || cap_valid;
    end
  end

endmodule : stim_one_decode

// File: rtl/stim_one_pkg.sv
// constants and types for the first-stimulus response decoder
// Contract
// - select 000 takes vbus ready before the port switch closes as the stimulus, without waiting for removal.
// - select 001 and 110 fire on the positive output above threshold, 011 on the negative output.
// - select 010 fires when the positive output is below threshold and above the fixed floor.
// - select 111 takes vbus present after the switch closes, no wait for removal; 100 and 101 never fire.
// - a do-not-use magnitude value is refused and the field keeps its previous setting.
// - for response codes 0001 to 0011 the magnitude picks the pin voltage, 0000 meaning pull-down.
// - for resistor responses the magnitude picks the resistor value.
// - for divider responses the magnitude picks the least total divider resistance.
// - response 0000 removes every response from both outputs.
// - codes 0001-0011 drive voltage and 0100, 0111, 1101 a resistor on positive, negative or both.
// - codes 0110, 1001, 1100 tap a divider; 1010 bridges the outputs; 0101, 1000, 1011 do nothing.
// - codes 1110 and 1111 keep the reset pull-downs for select 000, drop them for 111, else no change.
// - an untouched pin keeps its reset pull-down only for select 000 with no other response on it.
// - voltage with magnitude 0000 turns on the pull-down current chosen by the current field.
// - the threshold is ignored for select 000 and 111, and threshold 1111 is refused.
// - the three registers are filled from internal memory for the active profile and read only.
package stim_one_pkg;

  // ==========================================================
  // register map and reset values
  localparam logic [7:0] ADDR_SEL_TIMER = 8'h31;
  localparam logic [7:0] ADDR_RESP_MAG  = 8'h32;
  localparam logic [7:0] ADDR_PD_TH     = 8'h33;
  localparam logic [7:0] RST_SEL_TIMER  = 8'h00;
  localparam logic [7:0] RST_RESP_MAG   = 8'h26;
  localparam logic [7:0] RST_PD_TH      = 8'h00;
  localparam logic [7:0] READ_UNMAPPED  = 8'h00;

  // ==========================================================
  // field positions
  localparam int SEL_LSB  = 0;
  localparam int RESP_LSB = 0;
  localparam int MAG_LSB  = 4;
  localparam int TH_LSB   = 0;
  localparam int PUPD_LSB = 4;

  // ==========================================================
  // stimulus select codes
  localparam logic [2:0] SEL_VBUS_PRE  = 3'h0;
  localparam logic [2:0] SEL_DP_HI_A   = 3'h1;
  localparam logic [2:0] SEL_DP_WINDOW = 3'h2;
  localparam logic [2:0] SEL_DM_HI     = 3'h3;
  localparam logic [2:0] SEL_DP_HI_B   = 3'h6;
  localparam logic [2:0] SEL_VBUS_POST = 3'h7;

  // ==========================================================
  // response codes
  localparam logic [3:0] RESP_REMOVE    = 4'h0;
  localparam logic [3:0] RESP_VOLT_DP   = 4'h1;
  localparam logic [3:0] RESP_VOLT_DM   = 4'h2;
  localparam logic [3:0] RESP_VOLT_BOTH = 4'h3;
  localparam logic [3:0] RESP_RES_DP    = 4'h4;
  localparam logic [3:0] RESP_DIV_DP    = 4'h6;
  localparam logic [3:0] RESP_RES_DM    = 4'h7;
  localparam logic [3:0] RESP_DIV_DM    = 4'h9;
  localparam logic [3:0] RESP_BRIDGE    = 4'ha;
  localparam logic [3:0] RESP_DIV_BOTH  = 4'hc;
  localparam logic [3:0] RESP_RES_BOTH  = 4'hd;
  localparam logic [3:0] RESP_KEEP_A    = 4'he;
  localparam logic [3:0] RESP_KEEP_B    = 4'hf;

  localparam logic [3:0] MAG_PULLDOWN   = 4'h0;
  localparam logic [3:0] MAG_DO_NOT_USE = 4'hf;
  localparam logic [3:0] TH_DO_NOT_USE  = 4'hf;

  // ==========================================================
  // profile fetch: three bytes per profile, stride of four words
  localparam logic [1:0] LOAD_LAST   = 2'd2;
  localparam int         PROFILE_SHIFT = 2;

  typedef enum logic [1:0] {LOAD_IDLE, LOAD_FETCH, LOAD_DRAIN} load_state_t;

endpackage : stim_one_pkg

// File: rtl/profile_store.sv
// small profile memory with registered read data
`timescale 1ns/10ps
module profile_store #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  // clock
  input  wire logic             sys_clk,
  // programming port
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // read port
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  // ==========================================================
  // storage, no reset so it maps onto a plain array
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule : profile_store

// File: sim/stim_one_asserts.sv
// concurrent checks on the first-stimulus decoder ports
`timescale 1ns/10ps
module stim_one_asserts
  import stim_one_pkg::*;
(
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rstn,
  // load and read
  input wire logic       load_req,
  input wire logic       load_busy,
  input wire logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  // sequencing
  input wire logic       emu_reset,
  input wire logic       stim_hit,
  input wire logic [3:0] threshold_code,
  // switch controls
  input wire logic       dp_volt_en,
  input wire logic       dm_volt_en,
  input wire logic [3:0] volt_mag,
  input wire logic       dp_res_en,
  input wire logic       dm_res_en,
  input wire logic [3:0] res_mag,
  input wire logic       dp_div_en,
  input wire logic       dm_div_en,
  input wire logic [3:0] div_mag,
  input wire logic       bridge_en,
  input wire logic       dp_pd15k_en,
  input wire logic       dm_pd15k_en,
  input wire logic       pd_cur_en
);
  // ==========================================================
  // helpers
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic [8:0] ctl;
  assign ctl = {dp_volt_en, dm_volt_en, dp_res_en, dm_res_en, dp_div_en, dm_div_en,
                bridge_en, dp_pd15k_en, dm_pd15k_en};
  sequence load_go;
    load_req && !load_busy;
  endsequence
  sequence load_walk;
    load_busy [*5] ##1 !load_busy;
  endsequence
  // ==========================================================
  // properties
  load_len_a: assert property (load_go |=> load_walk)
    else $error("load busy window wrong");
  reset_vals_a: assert property ($rose(rstn) |-> rd_data == 8'h00 && ctl == 9'h003)
    else $error("reset state wrong");
  unmapped_rd_a: assert property (!(rd_addr inside {[8'h31:8'h33]}) |=> rd_data == READ_UNMAPPED)
    else $error("unmapped read not zero");
  hit_pulse_a: assert property (stim_hit |=> !stim_hit)
    else $error("hit longer than one cycle");
  ctl_hold_a: assert property ($changed(ctl) |-> stim_hit || $past(emu_reset) || !$past(rstn))
    else $error("controls moved without a fire");
  hit_idle_a: assert property (stim_hit |-> !$past(load_busy) && !$past(emu_reset))
    else $error("fire during load or reset");
  emu_clear_a: assert property (emu_reset |=> ctl == 9'h003 && !pd_cur_en)
    else $error("emulation reset state wrong");
  pd_cur_src_a: assert property ($rose(pd_cur_en) |-> volt_mag == MAG_PULLDOWN)
    else $error("pull-down current without pull-down voltage");
  mag_refuse_a: assert property (volt_mag != MAG_DO_NOT_USE && res_mag != MAG_DO_NOT_USE)
    else $error("do-not-use magnitude reached output");
  th_refuse_a: assert property (threshold_code != TH_DO_NOT_USE)
    else $error("do-not-use threshold reached output");
endmodule : stim_one_asserts

bind stim_one_decode stim_one_asserts u_chk (
  .sys_clk, .rstn, .load_req, .load_busy, .rd_addr, .rd_data, .emu_reset, .stim_hit,
  .threshold_code, .dp_volt_en, .dm_volt_en, .volt_mag, .dp_res_en, .dm_res_en, .res_mag,
  .dp_div_en, .dm_div_en, .div_mag, .bridge_en, .dp_pd15k_en, .dm_pd15k_en, .pd_cur_en
);

// File: sim/usb_dev_model.sv
// comparator-side model of the attached portable device
`timescale 1ns/10ps
module usb_dev_model (
  // clock and command
  input  wire logic       sys_clk,
  input  wire logic [2:0] mode,
  input  wire logic       on,
  // comparator pins
  output logic            vbus_ready_pin,
  output logic            vbus_present_pin,
  output logic            dp_above_th_pin,
  output logic            dm_above_th_pin,
  output logic            dp_above_floor_pin
);
  // ==========================================================
  // unselected comparators chatter so a wrong select cannot pass quietly
  logic noise = 1'b0;
  always @(posedge sys_clk) noise <= ~noise;
  assign vbus_ready_pin     = (mode == 3'h0) ? on : noise;
  assign vbus_present_pin   = (mode == 3'h7) ? on : noise;
  assign dp_above_th_pin    = (mode == 3'h1 || mode == 3'h6) ? on : (mode == 3'h2) ? ~on : noise;
  assign dm_above_th_pin    = (mode == 3'h3) ? on : noise;
  assign dp_above_floor_pin = (mode == 3'h2) ? on : noise;
endmodule : usb_dev_model

// File: sim/stim_one_decode_tb.sv
// self-checking bench for the first-stimulus decoder
`timescale 1ns/10ps
module stim_one_decode_tb;
  import stim_one_pkg::*;
  // ==========================================================
  // wiring
  logic       sys_clk, rstn, mem_wr_en, load_req, emu_reset, arm, on, load_busy, hit;
  logic       stim_hit, stim_done, vbus_ready_pin, vbus_present_pin, dp_above_th_pin;
  logic       dm_above_th_pin, dp_above_floor_pin, bridge_en, pd_cur_en;
  logic       dp_volt_en, dm_volt_en, dp_res_en, dm_res_en, dp_div_en, dm_div_en;
  logic       dp_pd15k_en, dm_pd15k_en;
  logic [5:0] mem_wr_addr;
  logic [7:0] mem_wr_data, rd_addr, rd_data, v, ua;
  logic [3:0] profile_sel, threshold_code, volt_mag, res_mag, div_mag, r, m, th, t, mg;
  logic [2:0] mode, s;
  logic [1:0] pd_cur_code, pu;
  logic [9:0] e;
  logic [7:0] ra [4];
  logic [7:0] rv [4];
  logic [2:0] sels [6];
  int         miscompares = 0, check_count = 0, cyc = 0, seed, i;
  wire logic [9:0] sw = {dp_volt_en, dm_volt_en, dp_res_en, dm_res_en, dp_div_en,
                         dm_div_en, bridge_en, dp_pd15k_en, dm_pd15k_en, pd_cur_en};

  stim_one_decode #(.AW(6)) DUT (
    .sys_clk, .rstn, .mem_wr_en, .mem_wr_addr, .mem_wr_data, .load_req, .profile_sel,
    .load_busy, .rd_addr, .rd_data, .emu_reset, .arm, .stim_hit, .stim_done,
    .vbus_ready_pin, .vbus_present_pin, .dp_above_th_pin, .dm_above_th_pin,
    .dp_above_floor_pin, .threshold_code, .dp_volt_en, .dm_volt_en, .volt_mag,
    .dp_res_en, .dm_res_en, .res_mag, .dp_div_en, .dm_div_en, .div_mag, .bridge_en,
    .dp_pd15k_en, .dm_pd15k_en, .pd_cur_en, .pd_cur_code
  );
  usb_dev_model PEER (
    .sys_clk, .mode, .on, .vbus_ready_pin, .vbus_present_pin, .dp_above_th_pin,
    .dm_above_th_pin, .dp_above_floor_pin
  );

  // ==========================================================
  // clock, timeout, verdict
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // ==========================================================
  // compares, expectation, drivers
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: byte %h expected %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_sw(input logic [9:0] got, input logic [9:0] exp, input logic [9:0] msk);
    check_count++;
    if ((got & msk) !== (exp & msk)) begin
      miscompares++;
      $display("ERROR %0t: switches %h expected %h", $time, got, exp);
    end
  endtask : chk_sw
  function automatic logic [9:0] exp_sw(input logic [3:0] c, input logic [2:0] sl,
                                         input logic [3:0] mag);
    logic [6:0] a;
    logic [1:0] pd;
    logic       tp;
    logic       tm;
    case (c)
      RESP_VOLT_DP:   a = 7'h40;
      RESP_VOLT_DM:   a = 7'h20;
      RESP_VOLT_BOTH: a = 7'h60;
      RESP_RES_DP:    a = 7'h10;
      RESP_RES_DM:    a = 7'h08;
      RESP_RES_BOTH:  a = 7'h18;
      RESP_DIV_DP:    a = 7'h04;
      RESP_DIV_DM:    a = 7'h02;
      RESP_DIV_BOTH:  a = 7'h06;
      RESP_BRIDGE:    a = 7'h01;
      default:        a = 7'h00;
    endcase
    tp = a[6] | a[4] | a[2] | a[0];
    tm = a[5] | a[3] | a[1] | a[0];
    if (a != 7'h00) pd = {~tp, ~tm} & {2{sl == SEL_VBUS_PRE}};
    else if (c == RESP_KEEP_A || c == RESP_KEEP_B) pd = (sl == SEL_VBUS_POST) ? 2'b00 : 2'b11;
    else pd = 2'b11;
    return {a, pd, (a[6] | a[5]) & (mag == MAG_PULLDOWN)};
  endfunction : exp_sw
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk) rd_addr = a;
    @(negedge sys_clk) d = rd_data;
  endtask : rd
  task automatic load(input logic [3:0] p, input logic [7:0] b0, b1, b2);
    logic [7:0] b [3];
    b = '{b0, b1, b2};
    for (int k = 0; k < 3; k++) begin
      @(negedge sys_clk);
      mem_wr_en = 1'b1;
      mem_wr_addr = {p, k[1:0]};
      mem_wr_data = b[k];
    end
    @(negedge sys_clk);
    mem_wr_en = 1'b0;
    load_req = 1'b1;
    profile_sel = p;
    @(negedge sys_clk) load_req = 1'b0;
    for (int k = 0; k < 20 && load_busy !== 1'b0; k++) @(negedge sys_clk);
  endtask : load
  // mode settles through the synchroniser before arming, so stale chatter cannot fire
  task automatic fire(input logic [2:0] md, input logic clr, output logic got);
    @(negedge sys_clk);
    emu_reset = clr;
    mode = md;
    repeat (3) @(negedge sys_clk) emu_reset = 1'b0;
    arm = 1'b1;
    @(negedge sys_clk) arm = 1'b0;
    on = 1'b1;
    got = 1'b0;
    for (int k = 0; k < 12 && !got; k++) @(negedge sys_clk) got = (stim_hit === 1'b1);
  endtask : fire

  // ==========================================================
  // main sequence
  initial begin
    seed = 38751;
    {rstn, mem_wr_en, load_req, emu_reset, arm, on} = '0;
    {mem_wr_addr, mem_wr_data, profile_sel, rd_addr, mode} = '0;
    sels = '{SEL_VBUS_PRE, SEL_DP_HI_A, SEL_DP_WINDOW, SEL_DM_HI, SEL_DP_HI_B, SEL_VBUS_POST};
    repeat (20) @(negedge sys_clk);
    rstn = 1'b1;
    ua = 8'h40 | 8'($random(seed));
    ra = '{ADDR_SEL_TIMER, ADDR_RESP_MAG, ADDR_PD_TH, ua};
    rv = '{RST_SEL_TIMER, RST_RESP_MAG, RST_PD_TH, READ_UNMAPPED};
    for (i = 0; i < 4; i++) begin
      rd(ra[i], v);
      chk_reg(v, rv[i]);
    end
    for (i = 0; i < 18; i++) begin
      r = (i < 16) ? (4'(i) ^ 4'h1) : (i == 16) ? RESP_KEEP_A : RESP_KEEP_B;
      s = (i == 16) ? SEL_VBUS_PRE : (i == 17) ? SEL_VBUS_POST : sels[$unsigned($random(seed)) % 6];
      m = (i % 3 == 0) ? MAG_PULLDOWN : 4'($unsigned($random(seed)) % 15);
      th = 4'($unsigned($random(seed)) % 15);
      t = 4'($random(seed));
      pu = 2'($random(seed));
      load(4'(i), {1'b1, t, s}, {m, r}, {2'b11, pu, th});
      rd(ADDR_SEL_TIMER, v);
      chk_reg(v, {1'b0, t, s});
      rd(ADDR_RESP_MAG, v);
      chk_reg(v, {m, r});
      rd(ADDR_PD_TH, v);
      chk_reg(v, {2'b00, pu, th});
      chk_reg({4'h0, threshold_code}, (s == 3'h0 || s == 3'h7) ? 8'h00 : {4'h0, th});
      fire(s, i != 1, hit);
      chk_sw(10'(hit), 10'h001, 10'h3ff);
      e = exp_sw(r, s, m);
      chk_sw(sw, e, (r == RESP_REMOVE) ? 10'h3f9 : 10'h3ff);
      mg = (e[9:8] != 0) ? volt_mag : (e[7:6] != 0) ? res_mag : (e[5:4] != 0) ? div_mag :
           volt_mag | res_mag | div_mag;
      chk_reg({4'h0, mg}, {4'h0, (e[9:4] != 0) ? m : 4'h0});
      if (e[0]) chk_reg({6'h00, pd_cur_code}, {6'h00, pu});
      on = 1'b0;
      repeat (5) @(negedge sys_clk);
      chk_sw(10'(stim_done), 10'h001, 10'h3ff);
    end
    load(4'h7, 8'h01, {4'h9, RESP_RES_DM}, {2'b00, 2'b01, 4'h3});
    load(4'h5, 8'h01, {MAG_DO_NOT_USE, RESP_RES_DP}, {2'b00, 2'b01, TH_DO_NOT_USE});
    rd(ADDR_RESP_MAG, v);
    chk_reg(v, {4'h9, RESP_RES_DP});
    rd(ADDR_PD_TH, v);
    chk_reg(v, {2'b00, 2'b01, 4'h3});
    for (i = 4; i < 6; i++) begin
      load(4'h6, 8'(i), 8'h01, 8'h00);
      fire(3'(i), 1'b1, hit);
      chk_sw(10'(hit), 10'h000, 10'h3ff);
      on = 1'b0;
    end
    close_out();
  end
endmodule : stim_one_decode_tb
